// ==== rtl/erim_pkg.sv ====
// constants and types of the event request and interrupt mapper
//
// Notes on behaviour
// - network mask bit set maps matching network request bit into frame event field
// - application mask routes request bits to host interrupt; host side writes only
// - network bit 0 set on latch capture, cleared by latch time read
// - network bit 2 set on link status change, cleared by its read
// - network bit 3 set on application status change, cleared by its read
// - network bits 4..11 mirror pending events of buffer manager channels 0..7
// - application bit 0 set on control write, cleared on control read
// - control event only generated while emulation enable is zero
// - application bit 1 set on latch input change, cleared by event time read
// - application bit 2 takes first sync pulse when mapped, cleared by its read
// - application bit 3 takes second sync pulse when mapped, cleared by its read
// - application bit 4 set on activation change, cleared by activation read
// - application bit 5 flags pending EEPROM command; host acknowledge clears it
// - application bits 8..23 mirror pending events of channels 0..15
// - two configuration bits select mapping of each sync pulse
package erim_pkg;

  localparam int ADDR_W = 16;
  localparam int WORD_LSB = 2;
  localparam logic [15:0] NET_MASK_ADDR = 16'h0200;
  localparam logic [15:0] APP_MASK_ADDR = 16'h0204;
  localparam logic [15:0] NET_REQ_ADDR = 16'h0210;
  localparam logic [15:0] APP_REQ_ADDR = 16'h0220;
  localparam logic [15:0] NET_MASK_RESET = 16'h0000;
  localparam logic [31:0] APP_MASK_RESET = 32'h00ff_ff0f;
  localparam logic [15:0] NET_VALID = 16'h0ffd;
  localparam logic [31:0] APP_VALID = 32'h00ff_ff3f;
  localparam int NET_LATCH_BIT = 0;
  localparam int NET_LINK_BIT = 2;
  localparam int NET_APPST_BIT = 3;
  localparam int NET_BM_LO = 4;
  localparam int NET_BM_N = 8;
  localparam int APP_CTRL_BIT = 0;
  localparam int APP_LATCH_BIT = 1;
  localparam int APP_FIRST_SYNC_PULSE_BIT = 2;
  localparam int APP_SECOND_SYNC_PULSE_BIT = 3;
  localparam int APP_BMACT_BIT = 4;
  localparam int APP_EEP_BIT = 5;
  localparam int APP_BM_LO = 8;
  localparam int APP_BM_N = 16;

  typedef struct packed {
    logic [15:0] net_req;
    logic [31:0] app_req;
  } erim_core_state_t;

  typedef struct packed {
    logic [15:0] net_mask;
    logic [31:0] app_mask;
    logic [31:0] net_rdata;
    logic [31:0] host_rdata;
    logic host_irq;
    logic [15:0] net_event_field;
  } erim_top_state_t;

endpackage

// ==== rtl/erim_evt_if.sv ====
// set, clear and request vectors between mapper top and event core
`timescale 1ns/10ps
`default_nettype none
interface erim_evt_if;
  logic [15:0] net_set;
  logic [15:0] net_clr;
  logic [15:0] net_req;
  logic [31:0] app_set;
  logic [31:0] app_clr;
  logic [31:0] app_req;
  modport ctl (output net_set, net_clr, app_set, app_clr, input net_req, app_req);
  modport core (input net_set, net_clr, app_set, app_clr, output net_req, app_req);
endinterface
`default_nettype wire

// ==== rtl/erim_event_core.sv ====
// sticky request bits of both request registers, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module erim_event_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  erim_evt_if.core ev
);

  erim_pkg::erim_core_state_t state;
  erim_pkg::erim_core_state_t next_state;

  always_comb
  begin
    next_state = state;
    if (ce)
    begin
      next_state.net_req = ((state.net_req & ~ev.net_clr) | ev.net_set) & erim_pkg::NET_VALID;
      next_state.app_req = ((state.app_req & ~ev.app_clr) | ev.app_set) & erim_pkg::APP_VALID;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= '0;
    else
      state <= next_state;
  end

  assign ev.net_req = state.net_req;
  assign ev.app_req = state.app_req;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  set_wins_app_a: assert property (ce |=> ((ev.app_req & $past(ev.app_set)) == $past(ev.app_set)))
    else $error("application set lost");
  clear_app_a: assert property (ce |=> ((ev.app_req & $past(ev.app_clr) & ~$past(ev.app_set)) == 0))
    else $error("application clear ignored");
  freeze_core_a: assert property (!ce |=> ($stable(ev.net_req) && $stable(ev.app_req)))
    else $error("core state moved without enable");

endmodule // erim_event_core
`default_nettype wire

// ==== rtl/erim_mapper.sv ====
// event request and interrupt mapper top with network and host register ports
`timescale 1ns/10ps
`default_nettype none
module erim_mapper (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // network side register port
  input wire logic [15:0] net_addr,
  input wire logic net_rd,
  input wire logic net_wr,
  input wire logic [3:0] net_be,
  input wire logic [31:0] net_wdata,
  output logic [31:0] net_rdata,
  // host process interface register port
  input wire logic [15:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [3:0] host_be,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  // event sources
  input wire logic latch_entry_captured,
  input wire logic latch_time_read,
  input wire logic link_status_changed,
  input wire logic link_status_read,
  input wire logic app_status_changed,
  input wire logic app_status_read,
  input wire logic [15:0] bm_event_pending,
  input wire logic app_control_written,
  input wire logic app_control_read,
  input wire logic emulation_enable,
  input wire logic latch_input_changed,
  input wire logic latch_event_time_read,
  input wire logic first_sync_pulse,
  input wire logic first_sync_map_en,
  input wire logic first_sync_state_read,
  input wire logic second_sync_pulse,
  input wire logic second_sync_map_en,
  input wire logic second_sync_state_read,
  input wire logic bm_activation_changed,
  input wire logic bm_activation_read,
  input wire logic eeprom_cmd_pending,
  input wire logic eeprom_cmd_ack,
  // mapped outputs
  output logic [15:0] net_event_field,
  output logic host_irq
);

  //////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic erim_hit(input logic [15:0] addr, input logic [15:0] off);
    return addr[erim_pkg::ADDR_W-1:erim_pkg::WORD_LSB] == off[erim_pkg::ADDR_W-1:erim_pkg::WORD_LSB];
  endfunction

  function automatic logic [31:0] erim_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] erim_read(
    input logic [15:0] addr,
    input logic [15:0] nm,
    input logic [31:0] am,
    input logic [15:0] nr,
    input logic [31:0] ar
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (erim_hit(addr, erim_pkg::NET_MASK_ADDR))
      r = {16'h0000, nm};
    else if (erim_hit(addr, erim_pkg::APP_MASK_ADDR))
      r = am;
    else if (erim_hit(addr, erim_pkg::NET_REQ_ADDR))
      r = {16'h0000, nr};
    else if (erim_hit(addr, erim_pkg::APP_REQ_ADDR))
      r = ar;
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // event core

  erim_evt_if ev ();

  erim_event_core u_core (
    .clk (clk),
    .rst_b (rst_b),
    .ce (ce),
    .ev (ev.core)
  );

  //////////////////////////////////////////////////////////////////////////
  // set and clear vectors

  always_comb
  begin
    ev.net_set = 16'h0000;
    ev.net_clr = 16'h0000;
    ev.app_set = 32'h0000_0000;
    ev.app_clr = 32'h0000_0000;
    ev.net_set[erim_pkg::NET_LATCH_BIT] = latch_entry_captured;
    ev.net_clr[erim_pkg::NET_LATCH_BIT] = latch_time_read;
    ev.net_set[erim_pkg::NET_LINK_BIT] = link_status_changed;
    ev.net_clr[erim_pkg::NET_LINK_BIT] = link_status_read;
    ev.net_set[erim_pkg::NET_APPST_BIT] = app_status_changed;
    ev.net_clr[erim_pkg::NET_APPST_BIT] = app_status_read;
    ev.net_set[erim_pkg::NET_BM_LO +: erim_pkg::NET_BM_N] = bm_event_pending[erim_pkg::NET_BM_N-1:0];
    ev.net_clr[erim_pkg::NET_BM_LO +: erim_pkg::NET_BM_N] = '1;
    ev.app_set[erim_pkg::APP_CTRL_BIT] = app_control_written & ~emulation_enable;
    ev.app_clr[erim_pkg::APP_CTRL_BIT] = app_control_read;
    ev.app_set[erim_pkg::APP_LATCH_BIT] = latch_input_changed;
    ev.app_clr[erim_pkg::APP_LATCH_BIT] = latch_event_time_read;
    ev.app_set[erim_pkg::APP_FIRST_SYNC_PULSE_BIT] = first_sync_pulse & first_sync_map_en;
    ev.app_clr[erim_pkg::APP_FIRST_SYNC_PULSE_BIT] = first_sync_state_read;
    ev.app_set[erim_pkg::APP_SECOND_SYNC_PULSE_BIT] = second_sync_pulse & second_sync_map_en;
    ev.app_clr[erim_pkg::APP_SECOND_SYNC_PULSE_BIT] = second_sync_state_read;
    ev.app_set[erim_pkg::APP_BMACT_BIT] = bm_activation_changed;
    ev.app_clr[erim_pkg::APP_BMACT_BIT] = bm_activation_read;
    ev.app_set[erim_pkg::APP_EEP_BIT] = eeprom_cmd_pending;
    ev.app_clr[erim_pkg::APP_EEP_BIT] = eeprom_cmd_ack;
    ev.app_set[erim_pkg::APP_BM_LO +: erim_pkg::APP_BM_N] = bm_event_pending;
    ev.app_clr[erim_pkg::APP_BM_LO +: erim_pkg::APP_BM_N] = '1;
  end

  //////////////////////////////////////////////////////////////////////////
  // registers and mapped outputs

  erim_pkg::erim_top_state_t state;
  erim_pkg::erim_top_state_t next_state;

  always_comb
  begin
    logic [31:0] net_merged;
    logic [31:0] app_merged;
    net_merged = erim_merge({16'h0000, state.net_mask}, net_wdata, net_be);
    app_merged = erim_merge(state.app_mask, host_wdata, host_be);
    next_state = state;
    if (ce)
    begin
      if (net_wr && erim_hit(net_addr, erim_pkg::NET_MASK_ADDR))
        next_state.net_mask = net_merged[15:0];
      if (host_wr && erim_hit(host_addr, erim_pkg::APP_MASK_ADDR))
        next_state.app_mask = app_merged;
      if (net_rd)
        next_state.net_rdata = erim_read(net_addr, state.net_mask, state.app_mask,
                                         ev.net_req, ev.app_req);
      if (host_rd)
        next_state.host_rdata = erim_read(host_addr, state.net_mask, state.app_mask,
                                          ev.net_req, ev.app_req);
      next_state.net_event_field = ev.net_req & state.net_mask;
      next_state.host_irq = |(ev.app_req & state.app_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state.net_mask <= erim_pkg::NET_MASK_RESET;
      state.app_mask <= erim_pkg::APP_MASK_RESET;
      state.net_rdata <= 32'h0000_0000;
      state.host_rdata <= 32'h0000_0000;
      state.host_irq <= 1'b0;
      state.net_event_field <= 16'h0000;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign net_rdata = state.net_rdata;
  assign host_rdata = state.host_rdata;
  assign net_event_field = state.net_event_field;
  assign host_irq = state.host_irq;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  irq_gating_a: assert property (
    ce |=> host_irq == |($past(ev.app_req) & $past(state.app_mask)))
    else $error("interrupt does not follow masked requests");

  reserved_zero_a: assert property (
    (ev.app_req & ~erim_pkg::APP_VALID) == 0 && (ev.net_req & ~erim_pkg::NET_VALID) == 0)
    else $error("reserved request bit set");

  field_map_a: assert property (
    ce |=> net_event_field == ($past(ev.net_req) & $past(state.net_mask)))
    else $error("event field not masked requests");

  net_mask_write_a: assert property (
    ce && net_wr && net_be == 4'hf && erim_hit(net_addr, erim_pkg::NET_MASK_ADDR)
    |=> state.net_mask == $past(net_wdata[15:0]))
    else $error("network mask write lost");

  app_mask_write_a: assert property (
    ce && host_wr && host_be == 4'hf && erim_hit(host_addr, erim_pkg::APP_MASK_ADDR)
    |=> state.app_mask == $past(host_wdata))
    else $error("application mask write lost");

  app_mask_owner_a: assert property (
    !(host_wr && erim_hit(host_addr, erim_pkg::APP_MASK_ADDR)) |=> $stable(state.app_mask))
    else $error("application mask changed without host write");

  latch_set_a: assert property (
    ce && latch_entry_captured |=> ev.net_req[erim_pkg::NET_LATCH_BIT])
    else $error("latch event not flagged");

  latch_clear_a: assert property (
    ce && latch_time_read && !latch_entry_captured |=> !ev.net_req[erim_pkg::NET_LATCH_BIT])
    else $error("latch event not cleared by read");

  link_event_a: assert property (
    ce && link_status_changed ##1 !ce [*2] |-> ev.net_req[erim_pkg::NET_LINK_BIT])
    else $error("link event not held while frozen");

  net_mirror_a: assert property (
    ce |=> ev.net_req[erim_pkg::NET_BM_LO +: erim_pkg::NET_BM_N]
           == $past(bm_event_pending[erim_pkg::NET_BM_N-1:0]))
    else $error("network mirror wrong");

  ctrl_event_a: assert property (
    ce && app_control_written && !emulation_enable |=> ev.app_req[erim_pkg::APP_CTRL_BIT])
    else $error("control write event missing");

  ctrl_emul_a: assert property (
    ce && app_control_written && emulation_enable && !ev.app_req[erim_pkg::APP_CTRL_BIT]
    |=> !ev.app_req[erim_pkg::APP_CTRL_BIT])
    else $error("control event under emulation");

  first_sync_pulse_unmapped_a: assert property (
    ce && !first_sync_map_en && !ev.app_req[erim_pkg::APP_FIRST_SYNC_PULSE_BIT]
    |=> !ev.app_req[erim_pkg::APP_FIRST_SYNC_PULSE_BIT])
    else $error("unmapped first sync reached request");

  eeprom_ack_a: assert property (
    ce && eeprom_cmd_ack && !eeprom_cmd_pending |=> !ev.app_req[erim_pkg::APP_EEP_BIT])
    else $error("acknowledge did not clear command flag");

  app_mirror_a: assert property (
    ce |=> ev.app_req[erim_pkg::APP_BM_LO +: erim_pkg::APP_BM_N] == $past(bm_event_pending))
    else $error("application mirror wrong");

  read_answer_a: assert property (
    ce && host_rd && erim_hit(host_addr, erim_pkg::APP_REQ_ADDR) |=> host_rdata == $past(ev.app_req))
    else $error("request read wrong");

  irq_path_c: cover property (ce && eeprom_cmd_pending ##1 ce ##1 host_irq);
  sync_map_c: cover property (ce && first_sync_pulse && first_sync_map_en ##1 ev.app_req[2]);
  emul_block_c: cover property (ce && app_control_written && emulation_enable);
  field_c: cover property (ce && link_status_changed ##2 net_event_field[2]);

endmodule // erim_mapper
`default_nettype wire

// ==== dv/erim_host_model.sv ====
// host process interface model: register accesses and command acknowledge
`timescale 1ns/10ps
`default_nettype none
module erim_host_model (
  input wire logic clk,
  input wire logic host_irq,
  input wire logic [31:0] host_rdata,
  input wire logic auto_ack,
  input wire logic [3:0] ack_wait,
  output logic [15:0] host_addr,
  output logic host_rd,
  output logic host_wr,
  output logic [3:0] host_be,
  output logic [31:0] host_wdata,
  output logic cmd_ack
);
  logic [31:0] rd_val;
  initial
  begin
    host_addr = 16'h0000;
    host_rd = 1'h0;
    host_wr = 1'h0;
    host_be = 4'h0;
    host_wdata = 32'h0000_0000;
    cmd_ack = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // host reads and writes registers
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_be = 4'hf;
    host_wr = wr;
    host_rd = !wr;
    @(negedge clk);
    q = host_rdata;
    host_rd = 1'h0;
    host_wr = 1'h0;
    // released lines must not keep the last value
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // acknowledge pending command
  always @(posedge clk)
    if (auto_ack && host_irq)
    begin
      acc(1'h0, erim_pkg::APP_REQ_ADDR, 32'h0000_0000, rd_val);
      if (rd_val[erim_pkg::APP_EEP_BIT])
      begin
        repeat (ack_wait) @(negedge clk);
        cmd_ack = 1'h1;
        @(negedge clk);
        cmd_ack = 1'h0;
        repeat (3) @(negedge clk);
      end
    end
endmodule // erim_host_model
`default_nettype wire

// ==== dv/erim_mapper_tb_top.sv ====
// self-checking bench of the event request and interrupt mapper
`timescale 1ns/10ps
`default_nettype none
module erim_mapper_tb_top;
  logic clk;
  logic rst_b;
  logic ce;
  logic [15:0] net_addr;
  logic net_rd;
  logic net_wr;
  logic [31:0] net_wdata;
  logic [31:0] net_rdata;
  logic [31:0] host_rdata;
  logic [15:0] host_addr;
  logic host_rd;
  logic host_wr;
  logic [3:0] host_be;
  logic [31:0] host_wdata;
  logic [8:0] sv;
  logic [8:0] cv;
  logic [15:0] bm;
  logic emu;
  logic map0;
  logic map1;
  logic m_ack;
  logic auto_ack;
  logic [3:0] ack_w;
  logic [15:0] nef;
  logic irq;
  logic [31:0] q;
  int bad_count;
  int tests_run;
  int cycles;
  // set/clear input index -> register (bit 5 high = application) and bit
  logic [5:0] rows [9] = '{6'h00, 6'h02, 6'h03, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25};
  //////////////////////////////////////////////////////////////////////////
  erim_mapper u_erim_mapper (.clk(clk), .rst_b(rst_b), .ce(ce), .net_addr(net_addr),
    .net_rd(net_rd), .net_wr(net_wr), .net_be(4'hf), .net_wdata(net_wdata),
    .net_rdata(net_rdata), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr),
    .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .latch_entry_captured(sv[0]), .latch_time_read(cv[0]), .link_status_changed(sv[1]),
    .link_status_read(cv[1]), .app_status_changed(sv[2]), .app_status_read(cv[2]),
    .bm_event_pending(bm), .app_control_written(sv[3]), .app_control_read(cv[3]),
    .emulation_enable(emu), .latch_input_changed(sv[4]), .latch_event_time_read(cv[4]),
    .first_sync_pulse(sv[5]), .first_sync_map_en(map0), .first_sync_state_read(cv[5]),
    .second_sync_pulse(sv[6]), .second_sync_map_en(map1), .second_sync_state_read(cv[6]),
    .bm_activation_changed(sv[7]), .bm_activation_read(cv[7]),
    .eeprom_cmd_pending(sv[8]), .eeprom_cmd_ack(cv[8] | m_ack),
    .net_event_field(nef), .host_irq(irq));
  erim_host_model u_erim_host_model (.clk(clk), .host_irq(irq), .host_rdata(host_rdata),
    .auto_ack(auto_ack), .ack_wait(ack_w), .host_addr(host_addr), .host_rd(host_rd),
    .host_wr(host_wr), .host_be(host_be), .host_wdata(host_wdata), .cmd_ack(m_ack));
  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t %s got %h exp %h", $time, m, got, exp);
      bad_count++;
    end
  endtask
  task automatic nacc(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    net_addr = a;
    net_wdata = d;
    net_wr = wr;
    net_rd = !wr;
    @(negedge clk);
    q = net_rdata;
    net_rd = 1'h0;
    net_wr = 1'h0;
    net_addr = ~a;
    net_wdata = ~d;
  endtask
  task automatic pulse(input logic [8:0] s, input logic [8:0] c);
    @(negedge clk);
    sv = s;
    cv = c;
    @(negedge clk);
    sv = 9'h000;
    cv = 9'h000;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  initial
  begin
    rst_b = 1'h0;
    ce = 1'h1;
    net_addr = 16'h0000;
    net_rd = 1'h0;
    net_wr = 1'h0;
    net_wdata = 32'h0000_0000;
    sv = 9'h000;
    cv = 9'h000;
    bm = 16'h0000;
    emu = 1'h0;
    map0 = 1'h1;
    map1 = 1'h1;
    auto_ack = 1'h0;
    ack_w = 4'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_b = 1'h1;
    nacc(1'h0, erim_pkg::NET_MASK_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0000, "network mask reset");
    u_erim_host_model.acc(1'h0, erim_pkg::APP_MASK_ADDR, 32'h0000_0000, q);
    chk(q, 32'h00ff_ff0f, "application mask reset");
    nacc(1'h0, erim_pkg::NET_REQ_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0000, "network request reset");
    chk({15'h0000, irq, nef}, 32'h0000_0000, "outputs reset");
    $display("reset test done");
    for (int i = 0; i < 9; i++)
    begin
      pulse(9'h001 << i, 9'h000);
      nacc(1'h0, rows[i][5] ? erim_pkg::APP_REQ_ADDR : erim_pkg::NET_REQ_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0001 << rows[i][4:0], "request set");
      pulse(9'h000, 9'h001 << i);
      nacc(1'h0, rows[i][5] ? erim_pkg::APP_REQ_ADDR : erim_pkg::NET_REQ_ADDR, 32'h0000_0000);
      chk(q, 32'h0000_0000, "request clear");
    end
    $display("sticky source test done");
    emu = 1'h1;
    map0 = 1'h0;
    map1 = 1'h0;
    pulse(9'h068, 9'h000);
    nacc(1'h0, erim_pkg::APP_REQ_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0000, "gated sources set");
    emu = 1'h0;
    pulse(9'h002, 9'h002);
    nacc(1'h0, erim_pkg::NET_REQ_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0004, "set beside clear");
    pulse(9'h000, 9'h002);
    $display("gating test done");
    nacc(1'h1, erim_pkg::NET_MASK_ADDR, 32'hffff_0ff0);
    nacc(1'h1, erim_pkg::APP_MASK_ADDR, 32'h0000_0000);
    u_erim_host_model.acc(1'h1, erim_pkg::NET_MASK_ADDR, 32'h0000_0000, q);
    u_erim_host_model.acc(1'h1, erim_pkg::APP_MASK_ADDR, 32'h0000_0020, q);
    nacc(1'h0, erim_pkg::NET_MASK_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0ff0, "network mask");
    u_erim_host_model.acc(1'h0, erim_pkg::APP_MASK_ADDR, 32'h0000_0000, q);
    chk(q, 32'h0000_0020, "application mask");
    bm = 16'ha5c3;
    repeat (2) @(negedge clk);
    nacc(1'h0, erim_pkg::NET_REQ_ADDR, 32'h0000_0000);
    chk(q, 32'h0000_0c30, "network mirror");
    nacc(1'h0, erim_pkg::APP_REQ_ADDR, 32'h0000_0000);
    chk(q, 32'h00a5_c300, "application mirror");
    chk({16'h0000, nef}, 32'h0000_0c30, "event field");
    chk({31'h0000_0000, irq}, 32'h0000_0000, "masked interrupt");
    $display("mask and mirror test done");
    auto_ack = 1'h1;
    for (int w = 0; w < 6; w += 5)
    begin
      ack_w = w[3:0];
      pulse(9'h100, 9'h000);
      for (int k = 0; k < 4 && irq !== 1'h1; k++)
        @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0001, "interrupt raised");
      for (int k = 0; k < 40 && irq !== 1'h0; k++)
        @(negedge clk);
      chk({31'h0000_0000, irq}, 32'h0000_0000, "interrupt cleared");
      nacc(1'h0, erim_pkg::APP_REQ_ADDR, 32'h0000_0000);
      chk(q, 32'h00a5_c300, "command acknowledged");
    end
    $display("command acknowledge test done");
    stop_test();
  end
endmodule // erim_mapper_tb_top
`default_nettype wire
